// ==== verilog/rllc_cfg.svh ====
// Purpose: constants of the replay length limit checker
// Assumes: register word width 32, offsets are byte addresses
// Notes: included by bare name
`ifndef RLLC_CFG_SVH
`define RLLC_CFG_SVH
`define RLLC_BYTES_PER_SAMPLE 36'h2
`define RLLC_MEM_SAMPLES_DEF 36'h020000000
`define RLLC_TOTAL_MIN 36'h10
`define RLLC_STEP_MASK 36'h7
`define RLLC_SEG_MIN 36'h8
`define RLLC_SEG_STREAM_MAX 36'h1fffffff8
`define RLLC_LOOP_SEG_MAX 32'h1
`define RLLC_LOOP_GATE_CUT 32'h1
`define RLLC_ADDR_CTRL 8'h00
`define RLLC_ADDR_MODE 8'h04
`define RLLC_ADDR_TOTAL_LO 8'h08
`define RLLC_ADDR_TOTAL_HI 8'h0c
`define RLLC_ADDR_SEG_LO 8'h10
`define RLLC_ADDR_SEG_HI 8'h14
`define RLLC_ADDR_REPEAT 8'h18
`define RLLC_ADDR_STATUS 8'h1c
`define RLLC_ADDR_IRQ_STAT 8'h20
`define RLLC_ADDR_IRQ_CLR 8'h24
`define RLLC_ADDR_IRQ_EN 8'h28
`define RLLC_ADDR_MEM_LO 8'h2c
`define RLLC_ADDR_MEM_HI 8'h30
`define RLLC_ADDR_FOOT_LO 8'h34
`define RLLC_ADDR_FOOT_HI 8'h38
`define RLLC_NUM_ERR 4
`define RLLC_NUM_IRQ 3
`define RLLC_IRQ_ERR 0
`define RLLC_IRQ_START 1
`define RLLC_IRQ_DONE 2
`endif

// ==== verilog/rllc_pkg.sv ====
// Purpose: types of the replay length limit checker
// Assumes: nothing
// Notes: modes follow the mode register encoding
package rllc_pkg;
  typedef enum logic [2:0] {
    RLLC_STD_SINGLE, RLLC_STD_RESTART, RLLC_STD_MULTI, RLLC_STD_GATE,
    RLLC_FIFO_SINGLE, RLLC_FIFO_MULTI, RLLC_FIFO_GATE, RLLC_MODE_BAD
  } rllc_mode_t;
  typedef enum logic [1:0] {
    RLLC_IDLE, RLLC_RUN
  } rllc_state_t;
endpackage

// ==== verilog/rllc_reg_word.sv ====
// Purpose: small register-out word store for the split 36 bit limits
// Assumes: one write port, registered read
// Notes: holds the segment and total words split in halves
`timescale 1ns/1ps
module rllc_reg_word (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic wr_in,
  input wire logic [1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [1:0] raddr_in,
  output logic [31:0] rdata_out,
  output logic [127:0] all_out
);
  logic [31:0] mem [4];
  logic [31:0] rdata;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] <= 32'h0;
      end
      rdata <= 32'h0;
    end else begin
      if (wr_in) begin
        mem[waddr_in] <= wdata_in;
      end
      rdata <= mem[raddr_in];
    end
  end
  assign rdata_out = rdata;
  assign all_out = {mem[3], mem[2], mem[1], mem[0]};
endmodule // rllc_reg_word

// ==== verilog/rllc_checker.sv ====
// Purpose: check replay length settings against memory and channel limits
// Assumes: software register port, one clock, async low reset
// Notes: start request is refused while any limit is broken
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rllc_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Function
// - each stored sample takes two bytes of sample memory.
// - total sample cap is installed memory divided by active channels.
// - non-streaming modes need total at least sixteen, multiple of eight.
// - segment at least eight in steps of eight; streaming single/segment caps.
// - total ignored when streaming; segment ignored in single, restart, gated.
// - repeat zero is endless; standard segmented and gated modes allow at most one.
// - memory limits come from installed memory, default 512 megasamples.
// - all counts are in samples, not bytes.
// - gated with repeat one stops once total count replayed.
module rllc_checker (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sample_tick_in,
  output logic [31:0] rdata_out,
  output logic config_error_out,
  output logic replay_run_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    rllc_pkg::rllc_state_t state;
    logic [2:0] mode;
    logic [1:0] chan_sel;
    logic [31:0] repeat_count;
    logic [35:0] mem_samples;
    logic [35:0] played;
    logic [`RLLC_NUM_ERR-1:0] err;
    logic [`RLLC_NUM_IRQ-1:0] irq_stat;
    logic [`RLLC_NUM_IRQ-1:0] irq_en;
    logic [31:0] rdata;
    logic sel_store;
    logic irq;
    logic run;
    logic cfg_err;
  } rllc_state_s_t;

  rllc_state_s_t cur;
  rllc_state_s_t next_cur;
  logic [31:0] store_rdata;
  logic [127:0] store_all;
  logic store_wr;
  logic [1:0] store_waddr;
  logic [1:0] store_raddr;

  function automatic logic [1:0] rllc_store_idx(input logic [7:0] a);
    case (a)
      `RLLC_ADDR_TOTAL_LO: rllc_store_idx = 2'h0;
      `RLLC_ADDR_TOTAL_HI: rllc_store_idx = 2'h1;
      `RLLC_ADDR_SEG_LO: rllc_store_idx = 2'h2;
      default: rllc_store_idx = 2'h3;
    endcase
  endfunction

  function automatic logic rllc_is_store(input logic [7:0] a);
    rllc_is_store = (a == `RLLC_ADDR_TOTAL_LO) || (a == `RLLC_ADDR_TOTAL_HI) ||
                    (a == `RLLC_ADDR_SEG_LO) || (a == `RLLC_ADDR_SEG_HI);
  endfunction

  assign store_wr = wr_in && rllc_is_store(addr_in);
  assign store_waddr = rllc_store_idx(addr_in);
  assign store_raddr = rllc_store_idx(addr_in);

  rllc_reg_word u_store (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .wr_in(store_wr),
    .waddr_in(store_waddr),
    .wdata_in(wdata_in),
    .raddr_in(store_raddr),
    .rdata_out(store_rdata),
    .all_out(store_all)
  );

  ////////////////////////////////////////////////////////////////////////
  // limit evaluation, all values in samples except the byte footprint
  logic [35:0] total_count;
  logic [35:0] seg_len;
  logic [35:0] total_max;
  logic [35:0] seg_max;
  logic [2:0] seg_shift;
  logic [35:0] footprint;
  logic uses_total;
  logic uses_seg;
  logic seg_mode;
  logic total_ok;
  logic seg_ok;
  logic loop_ok;
  logic mode_ok;
  rllc_pkg::rllc_mode_t mode_e;

  assign total_count = store_all[35:0];
  assign seg_len = store_all[99:64];
  assign mode_e = rllc_pkg::rllc_mode_t'(cur.mode);
  assign footprint = total_count * `RLLC_BYTES_PER_SAMPLE;
  assign total_max = cur.mem_samples >> cur.chan_sel;

  always_comb begin
    uses_total = 1'b0;
    uses_seg = 1'b0;
    seg_mode = 1'b0;
    mode_ok = 1'b1;
    seg_shift = {1'b0, cur.chan_sel} + 3'h1;
    seg_max = cur.mem_samples >> seg_shift;
    // eight channels keep the four-channel segment cap
    if (seg_max < (cur.mem_samples >> 3)) begin
      seg_max = cur.mem_samples >> 3;
    end
    case (mode_e)
      rllc_pkg::RLLC_STD_SINGLE, rllc_pkg::RLLC_STD_RESTART, rllc_pkg::RLLC_STD_GATE: begin
        uses_total = 1'b1;
        seg_mode = (mode_e == rllc_pkg::RLLC_STD_GATE);
      end
      rllc_pkg::RLLC_STD_MULTI: begin
        uses_total = 1'b1;
        uses_seg = 1'b1;
        seg_mode = 1'b1;
      end
      rllc_pkg::RLLC_FIFO_SINGLE: begin
        uses_seg = 1'b1;
        seg_max = `RLLC_SEG_STREAM_MAX;
      end
      rllc_pkg::RLLC_FIFO_MULTI: begin
        uses_seg = 1'b1;
      end
      rllc_pkg::RLLC_FIFO_GATE: begin
        uses_seg = 1'b0;
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase
  end

  assign total_ok = !uses_total || ((total_count >= `RLLC_TOTAL_MIN) &&
                    ((total_count & `RLLC_STEP_MASK) == 36'h0) && (total_count <= total_max));
  assign seg_ok = !uses_seg || ((seg_len >= `RLLC_SEG_MIN) &&
                  ((seg_len & `RLLC_STEP_MASK) == 36'h0) && (seg_len <= seg_max));
  assign loop_ok = !seg_mode || (cur.repeat_count <= `RLLC_LOOP_SEG_MAX);

  ////////////////////////////////////////////////////////////////////////
  // start, stop and event logic
  logic start_req;
  logic stop_req;
  logic [`RLLC_NUM_ERR-1:0] err_now;
  logic [`RLLC_NUM_IRQ-1:0] irq_set;

  assign start_req = wr_in && (addr_in == `RLLC_ADDR_CTRL) && wdata_in[0];
  assign stop_req = wr_in && (addr_in == `RLLC_ADDR_CTRL) && wdata_in[1];
  assign err_now = {!mode_ok, !loop_ok, !seg_ok, !total_ok};

  always_comb begin
    next_cur = cur;
    irq_set = '0;
    next_cur.err = err_now;
    next_cur.cfg_err = |err_now;
    next_cur.sel_store = rd_in && rllc_is_store(addr_in);
    if (wr_in) begin
      case (addr_in)
        `RLLC_ADDR_MODE: begin
          next_cur.mode = wdata_in[2:0];
          next_cur.chan_sel = wdata_in[5:4];
        end
        `RLLC_ADDR_REPEAT: next_cur.repeat_count = wdata_in;
        `RLLC_ADDR_IRQ_EN: next_cur.irq_en = wdata_in[`RLLC_NUM_IRQ-1:0];
        `RLLC_ADDR_MEM_LO: next_cur.mem_samples[31:0] = wdata_in;
        `RLLC_ADDR_MEM_HI: next_cur.mem_samples[35:32] = wdata_in[3:0];
        default: begin
        end
      endcase
    end
    case (cur.state)
      rllc_pkg::RLLC_IDLE: begin
        if (start_req) begin
          if (|err_now) begin
            irq_set[`RLLC_IRQ_ERR] = 1'b1;
          end else begin
            next_cur.state = rllc_pkg::RLLC_RUN;
            next_cur.played = 36'h0;
            irq_set[`RLLC_IRQ_START] = 1'b1;
          end
        end
      end
      rllc_pkg::RLLC_RUN: begin
        if (sample_tick_in) begin
          next_cur.played = cur.played + 36'h1;
        end
        // software stop wins over the gated cut
        if (stop_req) begin
          next_cur.state = rllc_pkg::RLLC_IDLE;
          irq_set[`RLLC_IRQ_DONE] = 1'b1;
        end else if (mode_e == rllc_pkg::RLLC_STD_GATE && cur.repeat_count == `RLLC_LOOP_GATE_CUT &&
                     sample_tick_in && (cur.played + 36'h1) >= total_count) begin
          next_cur.state = rllc_pkg::RLLC_IDLE;
          irq_set[`RLLC_IRQ_DONE] = 1'b1;
        end
        // zero repeat count never ends by itself
      end
      default: next_cur.state = rllc_pkg::RLLC_IDLE;
    endcase
    if (wr_in && addr_in == `RLLC_ADDR_IRQ_CLR) begin
      next_cur.irq_stat = cur.irq_stat & ~wdata_in[`RLLC_NUM_IRQ-1:0];
    end
    next_cur.irq_stat = next_cur.irq_stat | irq_set;
    next_cur.run = (next_cur.state == rllc_pkg::RLLC_RUN);
    next_cur.irq = |(next_cur.irq_stat & next_cur.irq_en);
    next_cur.rdata = 32'h0;
    if (rd_in) begin
      case (addr_in)
        `RLLC_ADDR_MODE: next_cur.rdata = {26'h0, cur.chan_sel, 1'b0, cur.mode};
        `RLLC_ADDR_REPEAT: next_cur.rdata = cur.repeat_count;
        `RLLC_ADDR_STATUS: next_cur.rdata = {26'h0, cur.run, cur.cfg_err, cur.err};
        `RLLC_ADDR_IRQ_STAT: next_cur.rdata = {29'h0, cur.irq_stat};
        `RLLC_ADDR_IRQ_EN: next_cur.rdata = {29'h0, cur.irq_en};
        `RLLC_ADDR_MEM_LO: next_cur.rdata = cur.mem_samples[31:0];
        `RLLC_ADDR_MEM_HI: next_cur.rdata = {28'h0, cur.mem_samples[35:32]};
        `RLLC_ADDR_FOOT_LO: next_cur.rdata = footprint[31:0];
        `RLLC_ADDR_FOOT_HI: next_cur.rdata = {28'h0, footprint[35:32]};
        default: next_cur.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= '0;
      cur.mem_samples <= `RLLC_MEM_SAMPLES_DEF;
      cur.cfg_err <= 1'b1;
      cur.err <= 4'h1;
    end else begin
      cur <= next_cur;
    end
  end

  // store words come from the memory's own read register
  always_comb begin
    rdata_out = cur.sel_store ? store_rdata : cur.rdata;
  end
  assign config_error_out = cur.cfg_err;
  assign replay_run_out = cur.run;
  assign irq_out = cur.irq;

endmodule // rllc_checker

// ==== verification/rllc_bind_checker.sv ====
// Purpose: port assertions for the replay length limit checker
// Assumes: limit registers shadowed from the write port
// Notes: settled means two idle edges since the last write
`timescale 1ns/1ps
`include "rllc_cfg.svh"
module rllc_bind_checker (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sample_tick_in,
  input wire logic [31:0] rdata_out,
  input wire logic config_error_out,
  input wire logic replay_run_out,
  input wire logic irq_out
);
  logic [35:0] tot;
  logic [35:0] seg;
  logic [35:0] mem;
  logic [31:0] rep;
  logic [2:0] md;
  logic [1:0] ch;
  logic [1:0] q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tot <= 36'h0;
      seg <= 36'h0;
      mem <= 36'h020000000;
      rep <= 32'h0;
      md <= 3'h0;
      ch <= 2'h0;
      q <= 2'h0;
    end else if (wr_in) begin
      q <= 2'h0;
      case (addr_in)
        `RLLC_ADDR_MODE: {ch, md} <= {wdata_in[5:4], wdata_in[2:0]};
        `RLLC_ADDR_TOTAL_LO: tot[31:0] <= wdata_in;
        `RLLC_ADDR_TOTAL_HI: tot[35:32] <= wdata_in[3:0];
        `RLLC_ADDR_SEG_LO: seg[31:0] <= wdata_in;
        `RLLC_ADDR_SEG_HI: seg[35:32] <= wdata_in[3:0];
        `RLLC_ADDR_REPEAT: rep <= wdata_in;
        `RLLC_ADDR_MEM_LO: mem[31:0] <= wdata_in;
        `RLLC_ADDR_MEM_HI: mem[35:32] <= wdata_in[3:0];
        default: ;
      endcase
    end else if (q != 2'h3) begin
      q <= q + 2'h1;
    end
  end
  wire logic st = q >= 2'h2;
  wire logic ctl = wr_in && (addr_in == `RLLC_ADDR_CTRL);
  wire logic std_bad = (tot < 36'h10) || (tot[2:0] != 3'h0) || (tot > (mem >> ch));
  wire logic fs_bad = (seg < 36'h8) || (seg[2:0] != 3'h0) || (seg > 36'h1fffffff8);
  ////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence s_start;
    ctl && wdata_in[1:0] == 2'h1 && !replay_run_out && st;
  endsequence
  property p_start; s_start ##0 !config_error_out |=> replay_run_out; endproperty
  property p_refuse; s_start ##0 config_error_out |=> !replay_run_out; endproperty
  property p_std; st && md <= 3'h1 |-> config_error_out == std_bad; endproperty
  property p_fseg; st && md == 3'h4 |-> config_error_out == fs_bad; endproperty
  property p_gate; st && md == 3'h6 |-> !config_error_out; endproperty
  property p_loop; st && md == 3'h3 && tot == 36'h10 && rep > 32'h1 |-> config_error_out; endproperty
  property p_foot; rd_in && addr_in == `RLLC_ADDR_FOOT_LO && st |=> rdata_out == {tot[30:0], 1'b0}; endproperty
  property p_endless; replay_run_out && rep == 32'h0 && !ctl |=> replay_run_out; endproperty
  a_start: assert property (p_start) else $error("legal start ignored");
  a_refuse: assert property (p_refuse) else $error("bad start accepted");
  a_std: assert property (p_std) else $error("total limit wrong");
  a_fseg: assert property (p_fseg) else $error("segment limit wrong");
  a_gate: assert property (p_gate) else $error("ignored field flagged");
  a_loop: assert property (p_loop) else $error("repeat limit missed");
  a_foot: assert property (p_foot) else $error("footprint wrong");
  a_endless: assert property (p_endless) else $error("endless run ended");
endmodule // rllc_bind_checker

// ==== verification/tb_top.sv ====
// Purpose: register level tests of the replay length limit checker
// Assumes: one clock, reads answer one cycle later
// Notes: mode byte is channel code in bits 5:4, mode in bits 2:0
`timescale 1ns/1ps
`include "rllc_cfg.svh"
module tb_top;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic sample_tick_in = 1'b0;
  logic [31:0] rdata_out;
  logic config_error_out;
  logic replay_run_out;
  logic irq_out;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  rllc_checker uut (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .sample_tick_in(sample_tick_in), .rdata_out(rdata_out),
    .config_error_out(config_error_out), .replay_run_out(replay_run_out), .irq_out(irq_out));
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk(36'(rdata_out), 36'(e));
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock_in);
      sample_tick_in <= 1'b1;
      @(posedge clock_in);
      sample_tick_in <= 1'b0;
    end
  endtask
  task automatic cfg(input logic [7:0] m, input logic [35:0] t, input logic [35:0] s, input logic [31:0] r,
    input logic e);
    wr(`RLLC_ADDR_MODE, {24'h0, m});
    wr(`RLLC_ADDR_TOTAL_LO, t[31:0]);
    wr(`RLLC_ADDR_TOTAL_HI, {28'h0, t[35:32]});
    wr(`RLLC_ADDR_SEG_LO, s[31:0]);
    wr(`RLLC_ADDR_SEG_HI, {28'h0, s[35:32]});
    wr(`RLLC_ADDR_REPEAT, r);
    repeat (2) @(posedge clock_in);
    #1 chk(36'(config_error_out), 36'(e));
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    #1 chk(36'({config_error_out, replay_run_out, irq_out}), 36'h4);
    rd(`RLLC_ADDR_MEM_LO, 32'h20000000);
    rd(8'hfc, 32'h0);
    cfg(8'h00, 36'h10, 36'h0, 32'h0, 1'b0);
    cfg(8'h00, 36'h8, 36'h0, 32'h0, 1'b1);
    rd(`RLLC_ADDR_STATUS, 32'h11);
    rd(`RLLC_ADDR_TOTAL_LO, 32'h8);
    cfg(8'h00, 36'h14, 36'h0, 32'h0, 1'b1);
    cfg(8'h31, 36'h4000000, 36'h0, 32'h0, 1'b0);
    cfg(8'h31, 36'h4000008, 36'h0, 32'h0, 1'b1);
    cfg(8'h02, 36'h10, 36'h10000000, 32'h1, 1'b0);
    cfg(8'h02, 36'h10, 36'h10000008, 32'h1, 1'b1);
    cfg(8'h22, 36'h10, 36'h4000008, 32'h1, 1'b1);
    cfg(8'h22, 36'h10, 36'h4000000, 32'h1, 1'b0);
    cfg(8'h32, 36'h10, 36'h4000000, 32'h1, 1'b0);
    cfg(8'h32, 36'h10, 36'h4000008, 32'h1, 1'b1);
    cfg(8'h02, 36'h10, 36'h4, 32'h1, 1'b1);
    cfg(8'h02, 36'h10, 36'h8, 32'h2, 1'b1);
    cfg(8'h03, 36'h10, 36'h0, 32'h2, 1'b1);
    cfg(8'h03, 36'h10, 36'h3, 32'h1, 1'b0);
    cfg(8'h04, 36'h0, 36'h1fffffff8, 32'hffffffff, 1'b0);
    cfg(8'h04, 36'h0, 36'h200000000, 32'h0, 1'b1);
    cfg(8'h15, 36'h0, 36'h8000000, 32'h0, 1'b0);
    cfg(8'h15, 36'h0, 36'h8000008, 32'h0, 1'b1);
    cfg(8'h06, 36'h5, 36'h5, 32'h7, 1'b0);
    cfg(8'h00, 36'h20000008, 36'h0, 32'h0, 1'b1);
    wr(`RLLC_ADDR_MEM_LO, 32'h40000000);
    cfg(8'h00, 36'h20000008, 36'h0, 32'h0, 1'b0);
    cfg(8'h00, 36'h123456788, 36'h0, 32'h0, 1'b1);
    rd(`RLLC_ADDR_FOOT_LO, 32'h468acf10);
    rd(`RLLC_ADDR_FOOT_HI, 32'h2);
    // refused start raises the error event
    wr(`RLLC_ADDR_IRQ_EN, 32'h7);
    cfg(8'h07, 36'h10, 36'h0, 32'h0, 1'b1);
    wr(`RLLC_ADDR_CTRL, 32'h1);
    #1 chk(36'(replay_run_out), 36'h0);
    rd(`RLLC_ADDR_IRQ_STAT, 32'h1);
    chk(36'(irq_out), 36'h1);
    wr(`RLLC_ADDR_IRQ_CLR, 32'h7);
    rd(`RLLC_ADDR_IRQ_STAT, 32'h0);
    chk(36'(irq_out), 36'h0);
    wr(`RLLC_ADDR_IRQ_EN, 32'h6);
    wr(`RLLC_ADDR_CTRL, 32'h1);
    rd(`RLLC_ADDR_IRQ_STAT, 32'h1);
    chk(36'(irq_out), 36'h0);
    wr(`RLLC_ADDR_IRQ_CLR, 32'h1);
    // gated run with one pass stops at the total count
    cfg(8'h03, 36'h10, 36'h0, 32'h1, 1'b0);
    wr(`RLLC_ADDR_CTRL, 32'h1);
    #1 chk(36'(replay_run_out), 36'h1);
    tick(15);
    #1 chk(36'(replay_run_out), 36'h1);
    tick(1);
    repeat (2) @(posedge clock_in);
    #1 chk(36'(replay_run_out), 36'h0);
    rd(`RLLC_ADDR_IRQ_STAT, 32'h6);
    chk(36'(irq_out), 36'h1);
    cfg(8'h00, 36'h10, 36'h0, 32'h0, 1'b0);
    wr(`RLLC_ADDR_CTRL, 32'h1);
    tick(40);
    #1 chk(36'(replay_run_out), 36'h1);
    wr(`RLLC_ADDR_CTRL, 32'h2);
    #1 chk(36'(replay_run_out), 36'h0);
    results();
  end
endmodule // tb_top
bind rllc_checker rllc_bind_checker chk_i (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sample_tick_in(sample_tick_in), .rdata_out(rdata_out),
  .config_error_out(config_error_out), .replay_run_out(replay_run_out), .irq_out(irq_out));
